// [core/secr_pkg.sv]
package secr_pkg;

	// ---------------------------------------------------------------
	// counters
	// ---------------------------------------------------------------
	localparam int          CNT_W       = 8;
	localparam logic [7:0]  CNT_MAX     = 8'hFF;
	localparam logic [7:0]  CNT_PRE_MAX = 8'hFE;
	localparam logic [7:0]  CNT_ZERO    = 8'h00;
	localparam int          N_ERR       = 3;
	localparam int          IDX_LINE    = 0;
	localparam int          IDX_BURST   = 1;
	localparam int          IDX_ARIFCI  = 2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int          REPORT_TIME_MS  = 2000;
	localparam int          CLK_MHZ         = 250;
	localparam int          REPORT_CYCLES   = REPORT_TIME_MS * 1000 * CLK_MHZ;
	localparam logic [2:0]  BURST_PREP_HB   = 3'h4;
	localparam logic [2:0]  BURST_ERR_HB    = 3'h5;

	// ---------------------------------------------------------------
	// report frame layout
	// ---------------------------------------------------------------
	localparam logic [3:0]  RPT_DST_CLASS   = 4'h6;
	localparam logic [3:0]  RPT_SRC_CLASS   = 4'h0;
	localparam logic [7:0]  SV_UPSTREAM     = 8'h02;
	localparam logic [7:0]  SV_PHYS_DROP    = 8'h0B;
	localparam logic [7:0]  SV_ISOLATING    = 8'h2D;
	localparam logic [7:0]  SV_NONISOLATING = 8'h2E;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0]  REG_RING_STATUS = 8'h00;
	localparam logic [7:0]  REG_ERROR_LOG   = 8'h04;
	localparam logic [7:0]  REG_RPT_PERIOD  = 8'h08;
	localparam logic [7:0]  REG_SOFT_COUNTS = 8'h0C;
	localparam logic [7:0]  REG_RPT_STATE   = 8'h10;
	localparam int          BIT_OVERFLOW    = 0;
	localparam logic [31:0] WORD_ZERO       = 32'h00000000;

	typedef enum logic [3:0] {
		SECR_IDLE    = 4'h1,
		SECR_TIMING  = 4'h2,
		SECR_QUEUED  = 4'h4,
		SECR_SENDING = 4'h8
	} secr_rpt_state_t;

	// end-of-frame summary from the receive path
	typedef struct packed {
		logic done;
		logic repeated_or_copied;
		logic is_token;
		logic error_seen_flag;
		logic code_violation;
		logic fcs_error;
	} secr_frame_t;

	// monitor present frame summary
	typedef struct packed {
		logic done;
		logic is_active;
		logic addr_recognized_frame_copied_bits_zero;
	} secr_mon_t;

	// half-bit line sampling
	typedef struct packed {
		logic tick;
		logic transition;
		logic in_frame;
	} secr_line_t;

	typedef struct packed {
		logic [3:0]  dst_class;
		logic [3:0]  src_class;
		logic [7:0]  sv_upstream;
		logic [47:0] upstream_neighbor_address;
		logic [7:0]  sv_phys_drop;
		logic [31:0] phys_drop;
		logic [7:0]  sv_isolating;
		logic [7:0]  line_cnt;
		logic [7:0]  burst_cnt;
		logic [7:0]  arifci_cnt;
		logic [7:0]  sv_nonisolating;
		logic [31:0] nonisolating_counts;
	} secr_report_t;

endpackage

// [core/secr_top.sv]
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// RQ1: ring counters step by one when inserted, normal, and below 255.
// RQ2: normal means no monitor contention, beacon or ring purge in progress.
// RQ3: any ring counter increment starts the report timer; an increment during SECR_QUEUED or SECR_SENDING leaves the timer stopped.
// RQ4: timer expiry queues a report, sent only in normal state.
// RQ5: after full transmission, reported values are subtracted, not cleared.
// RQ6: report goes out through the assured delivery mechanism.
// RQ7: beacon auto-removal cancels the timer; next report needs a new error.
// RQ8: timer period defaults to 2.0 s, reloadable from management frames.
// RQ9: report uses class 6/0, monitor address, four fixed subvectors.
// RQ10: host counter set steps under identical conditions, saturating at 255.
// RQ11: host counter stepping 254 to 255 sets ring status overflow bit.
// RQ12: host reads error log by command; the read resets host counters.
// RQ13: first detector sets error seen flag; already-set frames are not counted.
// RQ14: line error at most once per frame on violation or check error.
// RQ15: burst error after five half bits without transitions inside frame.
// RQ16: four silent half bits arm the transmitter to send idles.
// RQ17: address/copied error on repeated zero-bit monitor frames without active one.
// RQ18: counters are eight-bit unsigned and saturate rather than wrap.
module secr_top #(
	parameter int unsigned REPORT_CYCLES_DEF = secr_pkg::REPORT_CYCLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// station state
	input  wire logic                  inserted_i,
	input  wire logic                  in_contention_i,
	input  wire logic                  in_beacon_i,
	input  wire logic                  in_purge_i,
	input  wire logic                  auto_removal_i,
	// receive path summaries
	input  wire secr_pkg::secr_frame_t frame_i,
	input  wire secr_pkg::secr_mon_t   mon_i,
	input  wire secr_pkg::secr_line_t  line_i,
	output logic                       set_error_seen_flag_o,
	output logic                       tx_idles_o,
	// timer reload from management frames
	input  wire logic                  period_load_i,
	input  wire logic [31:0]           period_value_i,
	// report frame to assured delivery
	input  wire logic [47:0]           upstream_neighbor_address_i,
	input  wire logic [31:0]           phys_drop_i,
	input  wire logic [31:0]           nonisolating_counts_i,
	output logic                       rpt_req_o,
	output secr_pkg::secr_report_t     rpt_o,
	input  wire logic                  rpt_done_i
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic en);
		sat_inc = (en && v != secr_pkg::CNT_MAX) ? v + 8'h01 : v;
	endfunction

	logic                          normal;
	logic                          cnt_en;
	logic                          line_err;
	logic                          burst_err;
	logic                          arifci_err;
	logic [secr_pkg::N_ERR-1:0]    err;
	logic [secr_pkg::N_ERR-1:0]    soft_step;
	logic [secr_pkg::N_ERR-1:0]    host_step;
	logic [7:0]                    soft_r   [secr_pkg::N_ERR];
	logic [7:0]                    host_r   [secr_pkg::N_ERR];
	logic [7:0]                    snap_r   [secr_pkg::N_ERR];
	logic [2:0]                    quiet_r;
	logic                          prep_idle_r;
	logic                          mon_zero_seen_r;
	logic                          overflow_r;
	logic [31:0]                   period_r;
	logic [31:0]                   timer_r;
	secr_pkg::secr_rpt_state_t     state_r;
	secr_pkg::secr_rpt_state_t     state_nxt;
	logic                          bus_req;
	logic                          rd_log;
	logic                          rd_status;
	logic                          sent;

	// RQ2 normal state
	assign normal = !in_contention_i && !in_beacon_i && !in_purge_i;
	// RQ1 count gate
	assign cnt_en = inserted_i && normal;

	// ---------------------------------------------------------------
	// error detection
	// ---------------------------------------------------------------
	// RQ14 one line error per frame
	assign line_err = frame_i.done && frame_i.repeated_or_copied &&
		!frame_i.error_seen_flag &&
		(frame_i.code_violation || frame_i.fcs_error);
	// RQ15 five silent half bits
	assign burst_err = line_i.tick && line_i.in_frame && !line_i.transition &&
		quiet_r == secr_pkg::BURST_PREP_HB;
	// RQ17 repeated zero-bit monitor frame
	assign arifci_err = mon_i.done && mon_i.addr_recognized_frame_copied_bits_zero &&
		mon_zero_seen_r;

	assign err = {arifci_err, burst_err, line_err};

	// RQ13 mark frame for downstream stations
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			set_error_seen_flag_o <= 1'b0;
		else
			set_error_seen_flag_o <= line_err || burst_err;
	end

	// quiet half-bit count; saturates at the burst figure
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			quiet_r <= 3'h0;
		else if (!line_i.in_frame || (line_i.tick && line_i.transition))
			quiet_r <= 3'h0;
		else if (line_i.tick && quiet_r != secr_pkg::BURST_ERR_HB)
			quiet_r <= quiet_r + 3'h1;
	end

	// RQ16 arm idles at four, send them at five
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prep_idle_r <= 1'b0;
			tx_idles_o  <= 1'b0;
		end
		else
		begin
			if (!line_i.in_frame)
				prep_idle_r <= 1'b0;
			else if (line_i.tick && !line_i.transition &&
				quiet_r == secr_pkg::BURST_PREP_HB - 3'h1)
				prep_idle_r <= 1'b1;
			if (!line_i.in_frame)
				tx_idles_o <= 1'b0;
			else if (burst_err && prep_idle_r)
				tx_idles_o <= 1'b1;
		end
	end

	// RQ17 an active monitor frame with bits set breaks the run
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mon_zero_seen_r <= 1'b0;
		else if (mon_i.done)
		begin
			if (mon_i.addr_recognized_frame_copied_bits_zero)
				mon_zero_seen_r <= 1'b1;
			else if (mon_i.is_active)
				mon_zero_seen_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// counter sets
	// ---------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < secr_pkg::N_ERR; i++)
		begin
			soft_step[i] = err[i] && cnt_en && soft_r[i] != secr_pkg::CNT_MAX;
			host_step[i] = err[i] && cnt_en && host_r[i] != secr_pkg::CNT_MAX;
		end
	end

	assign sent = state_r == secr_pkg::SECR_SENDING && rpt_done_i;

	// RQ18 saturating ring counters
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < secr_pkg::N_ERR; i++)
				soft_r[i] <= secr_pkg::CNT_ZERO;
		end
		else
		begin
			for (int i = 0; i < secr_pkg::N_ERR; i++)
			begin
				// RQ5 subtract what was reported
				if (sent)
					soft_r[i] <= sat_inc(soft_r[i], soft_step[i]) - snap_r[i];
				else
					soft_r[i] <= sat_inc(soft_r[i], soft_step[i]);
			end
		end
	end

	// RQ10 host set; a step in the reading cycle survives the clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < secr_pkg::N_ERR; i++)
				host_r[i] <= secr_pkg::CNT_ZERO;
		end
		else
		begin
			for (int i = 0; i < secr_pkg::N_ERR; i++)
			begin
				// RQ12 read resets counters
				if (rd_log)
					host_r[i] <= sat_inc(secr_pkg::CNT_ZERO, host_step[i]);
				else
					host_r[i] <= sat_inc(host_r[i], host_step[i]);
			end
		end
	end

	// RQ11 overflow on 254 to 255; set wins over read clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			overflow_r <= 1'b0;
		else
		begin
			logic hit;
			hit = 1'b0;
			for (int i = 0; i < secr_pkg::N_ERR; i++)
				if (host_step[i] && host_r[i] == secr_pkg::CNT_PRE_MAX && !rd_log)
					hit = 1'b1;
			if (hit)
				overflow_r <= 1'b1;
			else if (rd_status)
				overflow_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// report timer and sequencing
	// ---------------------------------------------------------------
	// RQ8 period default and reload
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			period_r <= REPORT_CYCLES_DEF;
		else if (period_load_i)
			period_r <= period_value_i;
		else if (bus_req && wb_we_i && wb_adr_i == secr_pkg::REG_RPT_PERIOD &&
			&wb_sel_i)
			period_r <= wb_dat_i;
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			secr_pkg::SECR_IDLE:
				// RQ3 start timer on increment
				if (|soft_step)
					state_nxt = secr_pkg::SECR_TIMING;
			secr_pkg::SECR_TIMING:
				// RQ7 auto-removal cancels
				if (auto_removal_i)
					state_nxt = secr_pkg::SECR_IDLE;
				// RQ4 expiry queues the report
				else if (timer_r <= 32'h00000001)
					state_nxt = secr_pkg::SECR_QUEUED;
			secr_pkg::SECR_QUEUED:
				if (auto_removal_i)
					state_nxt = secr_pkg::SECR_IDLE;
				// RQ4 send only in normal state
				else if (normal)
					state_nxt = secr_pkg::SECR_SENDING;
			secr_pkg::SECR_SENDING:
				if (rpt_done_i)
					state_nxt = secr_pkg::SECR_IDLE;
			default:
				state_nxt = secr_pkg::SECR_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_r <= secr_pkg::SECR_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			timer_r <= 32'h00000000;
		else if (state_r != secr_pkg::SECR_TIMING)
			timer_r <= period_r;
		else if (timer_r != 32'h00000000)
			timer_r <= timer_r - 32'h00000001;
	end

	// snapshot frozen while the frame is in flight
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < secr_pkg::N_ERR; i++)
				snap_r[i] <= secr_pkg::CNT_ZERO;
			rpt_o <= '0;
		end
		else if (state_r == secr_pkg::SECR_QUEUED && state_nxt == secr_pkg::SECR_SENDING)
		begin
			for (int i = 0; i < secr_pkg::N_ERR; i++)
				snap_r[i] <= soft_r[i];
			// RQ9 fixed frame header and subvectors
			rpt_o.dst_class                 <= secr_pkg::RPT_DST_CLASS;
			rpt_o.src_class                 <= secr_pkg::RPT_SRC_CLASS;
			rpt_o.sv_upstream               <= secr_pkg::SV_UPSTREAM;
			rpt_o.upstream_neighbor_address <= upstream_neighbor_address_i;
			rpt_o.sv_phys_drop              <= secr_pkg::SV_PHYS_DROP;
			rpt_o.phys_drop                 <= phys_drop_i;
			rpt_o.sv_isolating              <= secr_pkg::SV_ISOLATING;
			rpt_o.line_cnt                  <= soft_r[secr_pkg::IDX_LINE];
			rpt_o.burst_cnt                 <= soft_r[secr_pkg::IDX_BURST];
			rpt_o.arifci_cnt                <= soft_r[secr_pkg::IDX_ARIFCI];
			rpt_o.sv_nonisolating           <= secr_pkg::SV_NONISOLATING;
			rpt_o.nonisolating_counts       <= nonisolating_counts_i;
		end
	end

	// RQ6 held to the assured delivery engine until done
	assign rpt_req_o = state_r == secr_pkg::SECR_SENDING;

	// ---------------------------------------------------------------
	// wishbone slave
	// ---------------------------------------------------------------
	assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_log    = bus_req && !wb_we_i && wb_adr_i == secr_pkg::REG_ERROR_LOG;
	assign rd_status = bus_req && !wb_we_i && wb_adr_i == secr_pkg::REG_RING_STATUS;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= secr_pkg::WORD_ZERO;
		end
		else
		begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
			begin
				unique case (wb_adr_i)
					secr_pkg::REG_RING_STATUS:
						wb_dat_o <= {31'h00000000, overflow_r};
					secr_pkg::REG_ERROR_LOG:
						wb_dat_o <= {8'h00, host_r[secr_pkg::IDX_ARIFCI],
							host_r[secr_pkg::IDX_BURST], host_r[secr_pkg::IDX_LINE]};
					secr_pkg::REG_RPT_PERIOD:
						wb_dat_o <= period_r;
					secr_pkg::REG_SOFT_COUNTS:
						wb_dat_o <= {8'h00, soft_r[secr_pkg::IDX_ARIFCI],
							soft_r[secr_pkg::IDX_BURST], soft_r[secr_pkg::IDX_LINE]};
					secr_pkg::REG_RPT_STATE:
						wb_dat_o <= {28'h0000000, state_r};
					default:
						wb_dat_o <= secr_pkg::WORD_ZERO;
				endcase
			end
		end
	end

endmodule // secr_top

// [test/secr_sva.sv]
`timescale 1ns/1ps
module secr_sva (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   wb_ack_o,
	input wire logic                   inserted_i,
	input wire logic                   in_contention_i,
	input wire logic                   in_beacon_i,
	input wire logic                   in_purge_i,
	input wire logic                   auto_removal_i,
	input wire secr_pkg::secr_frame_t  frame_i,
	input wire secr_pkg::secr_line_t   line_i,
	input wire logic                   set_error_seen_flag_o,
	input wire logic                   tx_idles_o,
	input wire logic                   rpt_req_o,
	input wire secr_pkg::secr_report_t rpt_o,
	input wire logic                   rpt_done_i,
	input wire logic [47:0]            upstream_neighbor_address_i,
	input wire logic [31:0]            phys_drop_i,
	input wire logic [31:0]            nonisolating_counts_i
);
	wire nrm = !in_contention_i && !in_beacon_i && !in_purge_i;
	wire lerr = frame_i.done && frame_i.repeated_or_copied && !frame_i.error_seen_flag;
	wire bad = frame_i.code_violation || frame_i.fcs_error;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// --------
	// properties
	// --------
	property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack too long");
	property p_flag; lerr && bad && inserted_i && nrm |=> set_error_seen_flag_o; endproperty
	a_flag: assert property (p_flag) else $error("no flag");
	property p_nrm; $rose(rpt_req_o) |-> $past(nrm); endproperty
	a_nrm: assert property (p_nrm) else $error("report not normal");
	property p_hold; rpt_req_o && !rpt_done_i |=> rpt_req_o; endproperty
	a_hold: assert property (p_hold) else $error("report dropped");
	property p_end; rpt_req_o && rpt_done_i |=> !rpt_req_o; endproperty
	a_end: assert property (p_end) else $error("report kept");
	property p_hdr;
		rpt_req_o |-> rpt_o.dst_class == 4'h6 && rpt_o.src_class == 4'h0
			&& rpt_o.sv_upstream == 8'h02 && rpt_o.sv_phys_drop == 8'h0B
			&& rpt_o.sv_isolating == 8'h2D && rpt_o.sv_nonisolating == 8'h2E;
	endproperty
	a_hdr: assert property (p_hdr) else $error("bad header");
	property p_fld;
		$rose(rpt_req_o) |->
			rpt_o.upstream_neighbor_address == $past(upstream_neighbor_address_i)
			&& rpt_o.phys_drop == $past(phys_drop_i)
			&& rpt_o.nonisolating_counts == $past(nonisolating_counts_i);
	endproperty
	a_fld: assert property (p_fld) else $error("report fields not sampled");
	property p_idle; $rose(tx_idles_o) |-> $past(line_i.in_frame); endproperty
	a_idle: assert property (p_idle) else $error("idles outside frame");
	property p_cancel; auto_removal_i && !rpt_req_o |=> !rpt_req_o; endproperty
	a_cancel: assert property (p_cancel) else $error("report not cancelled");
	c_rpt: cover property ($rose(rpt_req_o));
	c_idle: cover property ($rose(tx_idles_o));
	c_flag: cover property (set_error_seen_flag_o);
endmodule // secr_sva

bind secr_top secr_sva u_sva (.clk_i, .rst_i, .wb_ack_o, .inserted_i, .in_contention_i,
	.in_beacon_i, .in_purge_i, .auto_removal_i, .frame_i, .line_i, .set_error_seen_flag_o,
	.tx_idles_o, .rpt_req_o, .rpt_o, .rpt_done_i, .upstream_neighbor_address_i, .phys_drop_i,
	.nonisolating_counts_i);

// [test/secr_err_monitor.sv]
`timescale 1ns/1ps
module secr_err_monitor (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   rpt_req_i,
	input  wire secr_pkg::secr_report_t rpt_i,
	input  wire logic [7:0]             lag_i,
	output logic                        done_o = 1'b0,
	output logic [23:0]                 got_o
);
	logic [7:0] wait_r = 8'h00;
	// --------
	// delivery
	// --------
	// delivered after lag
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		if (rst_i || !rpt_req_i || done_o)
			wait_r <= 8'h00;
		else if (wait_r == lag_i)
		begin
			done_o <= 1'b1;
			got_o <= {rpt_i.arifci_cnt, rpt_i.burst_cnt, rpt_i.line_cnt};
		end
		else
			wait_r <= wait_r + 8'h01;
	end
endmodule // secr_err_monitor

// [test/secr_top_tb_top.sv]
`timescale 1ns/1ps
module secr_top_tb_top;
	localparam int PER = 30;
	logic         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic         wb_we_i = 1'b0, inserted_i = 1'b1, in_contention_i = 1'b0;
	logic         in_beacon_i = 1'b0, in_purge_i = 1'b0, auto_removal_i = 1'b0;
	logic         period_load_i = 1'b0, wb_ack_o, set_error_seen_flag_o;
	logic         tx_idles_o, rpt_req_o, rpt_done_i;
	logic [2:0]   mon_i = 3'h0, line_i = 3'h0;
	logic [3:0]   wb_sel_i = 4'hF;
	logic [5:0]   frame_i = 6'h00, f;
	logic [7:0]   wb_adr_i = 8'h00, sl = 8'h00;
	logic [23:0]  got;
	logic [31:0]  wb_dat_i = 32'h0, period_value_i = 32'h0, wb_dat_o, r, ext = 32'h0;
	logic [31:0]  seed = 32'h0000BDA7, exp_q[$];
	logic [175:0] rpt_o;
	int           miscompares = 0, n_checks = 0, cyc_n = 0;

	secr_top #(.REPORT_CYCLES_DEF(PER)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .inserted_i, .in_contention_i,
		.in_beacon_i, .in_purge_i, .auto_removal_i, .frame_i, .mon_i, .line_i,
		.set_error_seen_flag_o, .tx_idles_o, .period_load_i, .period_value_i,
		.upstream_neighbor_address_i({ext, 16'h0000}), .phys_drop_i(~ext),
		.nonisolating_counts_i(ext), .rpt_req_o, .rpt_o, .rpt_done_i);
	secr_err_monitor u_mon (.clk_i, .rst_i, .rpt_req_i(rpt_req_o), .rpt_i(rpt_o),
		.lag_i(8'h10), .done_o(rpt_done_i), .got_o(got));

	// --------
	// clock, watcher, timeout
	// --------
	always #2 clk_i = ~clk_i;
	// registered copy keeps random inputs off the sampling edge
	always @(posedge clk_i) ext <= seed;
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk(wb_dat_o, exp_q.pop_front());
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 4000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task end_sim();
		// a read that never got its answer is a mismatch too
		if (exp_q.size() != 0)
			miscompares++;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		n_checks++;
		if (got_v !== exp_v)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got_v, exp_v);
		end
	endtask
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// --------
	// drivers
	// --------
	task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 4'hF, rnd());
	endtask
	task frm(input logic [5:0] v);
		frame_i <= v;
		@(posedge clk_i);
	endtask
	task tick(input logic t);
		line_i <= {1'b1, t, 1'b1};
		@(posedge clk_i);
	endtask
	task mon(input logic [2:0] v);
		mon_i <= v;
		@(posedge clk_i);
	endtask

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h10, 32'h1);
		rd(8'h08, 32'(PER));
		rd(8'h1C, 32'h0);
		period_value_i <= 32'h2710;
		period_load_i <= 1'b1;
		@(posedge clk_i);
		period_load_i <= 1'b0;
		bus(1'b1, 8'h08, 4'h3, 32'h5);
		rd(8'h08, 32'h2710);
		repeat (24)
		begin
			r = rnd();
			f = {1'b1, r[4:0]};
			sl += {7'h0, f[4] && !f[2] && (f[1] || f[0])};
			frm(f);
		end
		frm(6'h00);
		rd(8'h0C, {24'h0, sl});
		rd(8'h04, {24'h0, sl});
		rd(8'h04, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			{inserted_i, in_contention_i, in_beacon_i, in_purge_i} <= 4'h8 ^ (4'h8 >> i);
			frm(6'h32);
		end
		{inserted_i, in_contention_i, in_beacon_i, in_purge_i} <= 4'h8;
		frm(6'h00);
		rd(8'h0C, {24'h0, sl});
		for (int i = 0; i < 10; i++)
			tick(i == 4);
		line_i <= 3'h1;
		repeat (2) @(posedge clk_i);
		chk({31'h0, tx_idles_o}, 32'h1);
		line_i <= 3'h0;
		repeat (2) @(posedge clk_i);
		chk({31'h0, tx_idles_o}, 32'h0);
		mon(3'h5);
		mon(3'h5);
		mon(3'h6);
		mon(3'h5);
		mon(3'h0);
		rd(8'h0C, {16'h0101, sl});
		auto_removal_i <= 1'b1;
		@(posedge clk_i);
		auto_removal_i <= 1'b0;
		rd(8'h10, 32'h1);
		bus(1'b1, 8'h08, 4'hF, 32'(PER));
		frm(6'h32);
		frm(6'h00);
		sl++;
		rd(8'h10, 32'h2);
		in_purge_i <= 1'b1;
		repeat (PER + 9) @(posedge clk_i);
		rd(8'h10, 32'h4);
		in_purge_i <= 1'b0;
		while (rpt_req_o !== 1'b1)
			@(posedge clk_i);
		frm(6'h31);
		frm(6'h00);
		rd(8'h10, 32'h8);
		while (rpt_req_o === 1'b1)
			@(posedge clk_i);
		chk({8'h0, got}, {16'h0101, sl});
		rd(8'h0C, 32'h1);
		rd(8'h04, 32'h00010102);
		bus(1'b1, 8'h08, 4'hF, 32'h2710);
		repeat (256) frm(6'h31);
		frm(6'h00);
		rd(8'h04, 32'h000000FF);
		rd(8'h00, 32'h1);
		rd(8'h00, 32'h0);
		rd(8'h0C, 32'h000000FF);
		end_sim();
	end
endmodule // secr_top_tb_top
